/* File: adrc_defs.svh */
`ifndef ADRC_DEFS_SVH
`define ADRC_DEFS_SVH

// register byte offsets
`define ADRC_OFS_CONFIG 8'h00
`define ADRC_OFS_PHASE 8'h04
`define ADRC_OFS_DATA0 8'h08
`define ADRC_OFS_DATA1 8'h0c
`define ADRC_OFS_STATUS 8'h10

// configuration field positions
`define ADRC_CFG_SRST_LSB 0
`define ADRC_CFG_SD_LSB 2
`define ADRC_CFG_VREFX_BIT 4
`define ADRC_CFG_CLKX_BIT 5
`define ADRC_CFG_MODEN_LSB 6
`define ADRC_CFG_WIDTH 8

// status field positions
`define ADRC_ST_CORE_BIT 0
`define ADRC_ST_INPUT_BIT 1
`define ADRC_ST_FULL_BIT 2
`define ADRC_ST_SETTLE_LSB 3

// reset values
`define ADRC_CONFIG_RST 8'h00
`define ADRC_PHASE_RST 12'h000

// zero-output bitstream, sent msb first
`define ADRC_ZERO_PATTERN 4'h3

// data-rate periods before the first data-ready pulse after restart
`define ADRC_START_PERIODS 4'h3

// internal power-on reset pulse
`define ADRC_CLK_MHZ 200
`define ADRC_POR_TIME_NS 100
`define ADRC_POR_CYCLES ((`ADRC_POR_TIME_NS * `ADRC_CLK_MHZ + 999) / 1000)

// bus answers
`define ADRC_RESP_OKAY 2'h0
`define ADRC_RESP_SLVERR 2'h2

`endif

/* File: adrc_pkg.sv */
package adrc_pkg;

    typedef enum logic [1:0] {
        ADRC_RUN = 2'b00,
        ADRC_SOFT = 2'b01,
        ADRC_OFF = 2'b10
    } adrc_mode_t;

endpackage : adrc_pkg

/* File: adrc_chan.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adrc_defs.svh"

module adrc_chan #(
    parameter int DW = 24,
    parameter logic [3:0] SETTLE_PERIODS = 4'h3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic strobe,
    input wire adrc_pkg::adrc_mode_t mode,
    input wire logic mod_en,
    input wire logic mod_bit,
    input wire logic [DW-1:0] sample,
    output logic [DW-1:0] data_reg,
    output logic drdy_reg,
    output logic mod_out_reg,
    output logic mod_oe_reg,
    output logic settle_busy_reg
);
    logic [3:0] settle_reg;
    logic [1:0] pat_idx_reg;
    logic running;
    logic zero_bit;
    logic [3:0] pattern;

    assign pattern = `ADRC_ZERO_PATTERN;
    assign zero_bit = pattern[2'd3 - pat_idx_reg];

    always_comb begin
        unique case (mode)
            adrc_pkg::ADRC_RUN: running = 1'b1;
            adrc_pkg::ADRC_SOFT: running = 1'b0;
            adrc_pkg::ADRC_OFF: running = 1'b0;
            default: running = 1'b0;
        endcase
    end

    // settling count in data-rate periods
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_reg <= `ADRC_START_PERIODS;
        end else if (!running) begin
            settle_reg <= SETTLE_PERIODS;
        end else if (strobe && settle_reg != 4'h0) begin
            settle_reg <= settle_reg - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settle_busy_reg <= 1'b1;
        end else begin
            settle_busy_reg <= !running || settle_reg != 4'h0;
        end
    end

    // data register and data-ready
    always_ff @(posedge clk) begin
        if (rst) begin
            data_reg <= '0;
        end else if (!running) begin
            data_reg <= '0;
        end else if (strobe && settle_reg == 4'h0) begin
            data_reg <= sample;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drdy_reg <= 1'b0;
        end else begin
            drdy_reg <= strobe && running && settle_reg == 4'h0;
        end
    end

    // comparator state walks the zero pattern
    always_ff @(posedge clk) begin
        if (rst) begin
            pat_idx_reg <= 2'h0;
        end else if (tick) begin
            pat_idx_reg <= pat_idx_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mod_out_reg <= 1'b0;
            mod_oe_reg <= 1'b0;
        end else begin
            mod_oe_reg <= mod_en;
            mod_out_reg <= running ? mod_bit : zero_bit;
        end
    end

endmodule : adrc_chan
`default_nettype wire

/* File: adrc_ctrl.sv */
// Functional notes
// - soft-reset bit set puts channel in soft reset; clearing it leaves.
// - soft reset clears only that channel's data register.
// - no data-ready pulse from a channel in soft reset.
// - enabled bitstream output repeats 0011 during soft reset or shutdown.
// - leaving soft reset keeps phase delay, resynchronised to running channel.
// - one channel in soft reset never stops the shared clock; the code stops it when the other channel is in shutdown.
// - both channels in soft reset stop core clock; resumes automatically.
// - both in soft reset, input structure stays clocked.
// - reset pin low or power-on reset returns all registers to default.
// - hard reset clears data, filters, forces comparators to 0011.
// - hard reset puts both bitstream outputs in high impedance.
// - hard reset holds serial interface; host waits for release.
// - after shutdown clears, first data-ready follows filter settling.
// - shutdown per channel only by its bit; configuration untouched.
// - shutdown flushes data to zero and stops data-ready pulses.
// - leaving shutdown keeps phase delay, resyncs to active channel.
// - both in shutdown withholds clock from input and core.
// - both shutdown plus both external selects is full shutdown.
// - leaving full shutdown restarts monitors and performs power-on reset.
// - after full shutdown, first data-ready after three data-rate periods.
`timescale 1ns/10ps
`default_nettype none
`include "adrc_defs.svh"

module adrc_ctrl #(
    parameter int DW = 24,
    parameter int OSR_TICKS = 256,
    parameter int PHW = 12,
    parameter logic [3:0] SETTLE_PERIODS = 4'h3
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic RESET_N_PIN,
    input wire logic MCLK_IN,
    input wire logic [DW-1:0] SAMPLE0,
    input wire logic [DW-1:0] SAMPLE1,
    input wire logic MOD_BIT0,
    input wire logic MOD_BIT1,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [1:0] OUTPUT_RATE_CLOCK,
    output logic [1:0] MODULATOR_BITSTREAM_OUT,
    output logic [1:0] MODULATOR_BITSTREAM_OE,
    output logic CORE_CLK_EN,
    output logic INPUT_CLK_EN,
    output logic [1:0] BIAS_EN,
    output logic REF_EN,
    output logic SUPPLY_MON_EN,
    output logic FILTER_CLEAR
);
    localparam int CW = $clog2(OSR_TICKS);
    localparam int PORW = $clog2(`ADRC_POR_CYCLES + 1);

    // pin synchronisers
    logic rstn_meta_reg, rstn_sync_reg;
    logic mclk_meta_reg, mclk_sync_reg, mclk_prev_reg;
    logic tick;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rstn_meta_reg <= 1'b0;
            rstn_sync_reg <= 1'b0;
        end else begin
            rstn_meta_reg <= RESET_N_PIN;
            rstn_sync_reg <= rstn_meta_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mclk_meta_reg <= 1'b0;
            mclk_sync_reg <= 1'b0;
            mclk_prev_reg <= 1'b0;
        end else begin
            mclk_meta_reg <= MCLK_IN;
            mclk_sync_reg <= mclk_meta_reg;
            mclk_prev_reg <= mclk_sync_reg;
        end
    end

    assign tick = mclk_sync_reg && !mclk_prev_reg;

    // hard reset: system reset, pin low or internal power-on pulse
    logic [PORW-1:0] por_cnt_reg;
    logic hard;
    assign hard = SYS_RST || !rstn_sync_reg || por_cnt_reg != '0;

    // configuration
    logic [`ADRC_CFG_WIDTH-1:0] cfg_reg;
    logic [PHW-1:0] phase_reg;
    logic [1:0] srst, sd, mod_en;
    logic full_now, full_sd_reg;
    adrc_pkg::adrc_mode_t mode [2];

    assign srst = cfg_reg[`ADRC_CFG_SRST_LSB +: 2];
    assign sd = cfg_reg[`ADRC_CFG_SD_LSB +: 2];
    assign mod_en = cfg_reg[`ADRC_CFG_MODEN_LSB +: 2];
    assign full_now = sd == 2'h3 && cfg_reg[`ADRC_CFG_VREFX_BIT] && cfg_reg[`ADRC_CFG_CLKX_BIT];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (sd[i]) begin
                mode[i] = adrc_pkg::ADRC_OFF;
            end else if (srst[i]) begin
                mode[i] = adrc_pkg::ADRC_SOFT;
            end else begin
                mode[i] = adrc_pkg::ADRC_RUN;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (hard) begin
            full_sd_reg <= 1'b0;
        end else begin
            full_sd_reg <= full_now;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            por_cnt_reg <= '0;
        end else if (full_sd_reg && !full_now) begin
            por_cnt_reg <= PORW'(`ADRC_POR_CYCLES);
        end else if (por_cnt_reg != '0) begin
            por_cnt_reg <= por_cnt_reg - 1'b1;
        end
    end

    // shared data-rate counter; phase kept while stopped
    logic core_run;
    logic [CW-1:0] rate_cnt_reg;
    logic [1:0] strobe;
    assign core_run = mode[0] == adrc_pkg::ADRC_RUN || mode[1] == adrc_pkg::ADRC_RUN;

    always_ff @(posedge CLK) begin
        if (hard) begin
            rate_cnt_reg <= '0;
        end else if (tick && core_run) begin
            rate_cnt_reg <= rate_cnt_reg == CW'(OSR_TICKS - 1) ? '0 : rate_cnt_reg + 1'b1;
        end
    end

    assign strobe[0] = tick && core_run && rate_cnt_reg == '0;
    assign strobe[1] = tick && core_run && {{(32-CW){1'b0}}, rate_cnt_reg} == 32'(phase_reg);

    // channels
    logic [DW-1:0] sample [2];
    logic [DW-1:0] data [2];
    logic [1:0] drdy, mod_out, mod_oe, settle_busy, mod_bit;
    assign sample[0] = SAMPLE0;
    assign sample[1] = SAMPLE1;
    assign mod_bit = {MOD_BIT1, MOD_BIT0};

    for (genvar c = 0; c < 2; c++) begin : g_chan
        adrc_chan #(.DW(DW), .SETTLE_PERIODS(SETTLE_PERIODS)) u_chan (
            .clk(CLK),
            .rst(hard),
            .tick(tick),
            .strobe(strobe[c]),
            .mode(mode[c]),
            .mod_en(mod_en[c]),
            .mod_bit(mod_bit[c]),
            .sample(sample[c]),
            .data_reg(data[c]),
            .drdy_reg(drdy[c]),
            .mod_out_reg(mod_out[c]),
            .mod_oe_reg(mod_oe[c]),
            .settle_busy_reg(settle_busy[c])
        );
    end

    assign OUTPUT_RATE_CLOCK = drdy;
    assign MODULATOR_BITSTREAM_OUT = mod_out;
    assign MODULATOR_BITSTREAM_OE = mod_oe;

    // power and clock gating outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CORE_CLK_EN <= 1'b0;
            INPUT_CLK_EN <= 1'b0;
            BIAS_EN <= 2'h0;
            REF_EN <= 1'b0;
            SUPPLY_MON_EN <= 1'b1;
            FILTER_CLEAR <= 1'b1;
        end else begin
            CORE_CLK_EN <= core_run && !full_now;
            INPUT_CLK_EN <= sd != 2'h3 && !full_now;
            BIAS_EN <= ~sd;
            REF_EN <= !full_now;
            SUPPLY_MON_EN <= !full_now;
            FILTER_CLEAR <= hard;
        end
    end

    // AXI4-Lite slave, held idle during hard reset
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, wmask, st_word;
    logic [3:0] w_strb_reg;

    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign st_word = 32'({settle_busy, full_sd_reg, INPUT_CLK_EN, CORE_CLK_EN});

    always_ff @(posedge CLK) begin
        if (hard) begin
            S_AXI_AWREADY <= 1'b0;
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            S_AXI_AWREADY <= 1'b0;
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
            aw_hold_reg <= 1'b0;
        end else if ((S_AXI_BVALID && S_AXI_BREADY) || (!aw_hold_reg && !S_AXI_BVALID)) begin
            S_AXI_AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (hard) begin
            S_AXI_WREADY <= 1'b0;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            S_AXI_WREADY <= 1'b0;
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
            w_hold_reg <= 1'b0;
        end else if ((S_AXI_BVALID && S_AXI_BREADY) || (!w_hold_reg && !S_AXI_BVALID)) begin
            S_AXI_WREADY <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (hard) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `ADRC_RESP_OKAY;
        end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (aw_addr_reg == `ADRC_OFS_CONFIG || aw_addr_reg == `ADRC_OFS_PHASE) ?
                `ADRC_RESP_OKAY : `ADRC_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (hard) begin
            cfg_reg <= `ADRC_CONFIG_RST;
            phase_reg <= `ADRC_PHASE_RST;
        end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
            if (aw_addr_reg == `ADRC_OFS_CONFIG) begin
                cfg_reg <= (cfg_reg & ~wmask[`ADRC_CFG_WIDTH-1:0]) | (w_data_reg[`ADRC_CFG_WIDTH-1:0]
                    & wmask[`ADRC_CFG_WIDTH-1:0]);
            end
            if (aw_addr_reg == `ADRC_OFS_PHASE) begin
                phase_reg <= (phase_reg & ~wmask[PHW-1:0]) | (w_data_reg[PHW-1:0] & wmask[PHW-1:0]);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (hard) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `ADRC_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `ADRC_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `ADRC_OFS_CONFIG: S_AXI_RDATA <= 32'(cfg_reg);
                `ADRC_OFS_PHASE: S_AXI_RDATA <= 32'(phase_reg);
                `ADRC_OFS_DATA0: S_AXI_RDATA <= 32'(data[0]);
                `ADRC_OFS_DATA1: S_AXI_RDATA <= 32'(data[1]);
                `ADRC_OFS_STATUS: S_AXI_RDATA <= st_word;
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= `ADRC_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end else if (!S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // checks
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence seq_full_leave;
        full_sd_reg && !full_now && !hard;
    endsequence

    sequence seq_both_idle;
        !core_run && !hard;
    endsequence

    soft_no_drdy_a: assert property (mode[0] != adrc_pkg::ADRC_RUN |=> !OUTPUT_RATE_CLOCK[0])
        else $error("data-ready from stopped channel 0");
    data_flush_a: assert property (!hard && mode[1] != adrc_pkg::ADRC_RUN |=> data[1] == '0)
        else $error("channel 1 data not cleared");
    core_gate_a: assert property (seq_both_idle |=> !CORE_CLK_EN)
        else $error("core clock not gated");
    input_gate_a: assert property (sd == 2'h3 |=> !INPUT_CLK_EN)
        else $error("input clock not gated");
    soft_input_a: assert property (!hard && sd == 2'h0 && srst == 2'h3 |=> INPUT_CLK_EN)
        else $error("input clock stopped in soft reset");
    mod_hiz_a: assert property (hard |=> MODULATOR_BITSTREAM_OE == 2'h0)
        else $error("bitstream driven in hard reset");
    bus_hold_a: assert property (hard |=> !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_ARREADY)
        else $error("bus accepts during hard reset");
    por_exit_a: assert property (seq_full_leave |-> ##[1:3] (hard && FILTER_CLEAR) ##1 cfg_reg == `ADRC_CONFIG_RST)
        else $error("no reset after full shutdown exit");
    full_off_a: assert property (full_now && !hard |=> !REF_EN && !SUPPLY_MON_EN)
        else $error("reference or monitor on in full shutdown");
    sd_dom_a: assert property (!hard && sd[0] && srst[0] |=> !BIAS_EN[0])
        else $error("shutdown not dominant");
    stopped_rate_a: assert property (seq_both_idle ##1 !hard |-> $stable(rate_cnt_reg))
        else $error("phase counter moved while stopped");

endmodule : adrc_ctrl
`default_nettype wire

/* File: adrc_src.sv */
`timescale 1ns/10ps
`default_nettype none

module adrc_src (
    output logic MCLK,
    output logic [23:0] SAMPLE0,
    output logic [23:0] SAMPLE1,
    output logic MOD0,
    output logic MOD1
);
    // master clock of the converter, free running
    initial begin
        MCLK = 1'b0;
        forever #24 MCLK = ~MCLK;
    end
    // filter results and modulator bits of the two converters
    assign SAMPLE0 = 24'h5a5a5a;
    assign SAMPLE1 = 24'h3c3c3c;
    assign MOD0 = MCLK;
    assign MOD1 = ~MCLK;
endmodule : adrc_src

`default_nettype wire

/* File: test_adc_reset_shutdown_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adrc_defs.svh"

module test_adc_reset_shutdown_control;
    localparam int P = 77;
    localparam logic [7:0] CFG = `ADRC_OFS_CONFIG;
    localparam logic [7:0] PHS = `ADRC_OFS_PHASE;
    localparam logic [7:0] DT0 = `ADRC_OFS_DATA0;
    localparam logic [7:0] DT1 = `ADRC_OFS_DATA1;
    localparam logic [1:0] OK = `ADRC_RESP_OKAY;
    localparam logic [1:0] ERR = `ADRC_RESP_SLVERR;
    logic clk, sys_rst, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    wire logic mclk, m0, m1, awready, wready, bvalid, arready, rvalid, core_en, in_en, ref_en, mon_en, fclr;
    wire logic [23:0] s0, s1;
    wire logic [1:0] bresp, rresp, drdy, mout, moe, bias;
    wire logic [31:0] rdata;
    int failures, n_tests, c0, c1, cyc, t, d0, d1;

    adrc_src i_adrc_src (.MCLK(mclk), .SAMPLE0(s0), .SAMPLE1(s1), .MOD0(m0), .MOD1(m1));

    adrc_ctrl #(.OSR_TICKS(8)) i_adrc_ctrl (
        .CLK(clk), .SYS_RST(sys_rst), .RESET_N_PIN(rst_n), .MCLK_IN(mclk), .SAMPLE0(s0), .SAMPLE1(s1),
        .MOD_BIT0(m0), .MOD_BIT1(m1), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .OUTPUT_RATE_CLOCK(drdy), .MODULATOR_BITSTREAM_OUT(mout),
        .MODULATOR_BITSTREAM_OE(moe), .CORE_CLK_EN(core_en), .INPUT_CLK_EN(in_en), .BIAS_EN(bias),
        .REF_EN(ref_en), .SUPPLY_MON_EN(mon_en), .FILTER_CLEAR(fclr)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // data-ready pulse counters and cycle count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (drdy[0] === 1'b1) c0 <= c0 + 1;
        if (drdy[1] === 1'b1) c1 <= c1 + 1;
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task hang;
        failures++;
        $display("MISMATCH %0t wait ran out", $time);
        test_done();
    endtask : hang

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        logic got;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        got = 1'b0;
        for (i = 0; i < 100 && !got; i++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1'b1;
                bready <= 1'b0;
                chk(32'(bresp), 32'(r));
            end
        end
        if (!got) hang();
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int i;
        logic got;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        got = 1'b0;
        for (i = 0; i < 100 && !got; i++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = 1'b1;
                rready <= 1'b0;
                chk(rdata, e);
                chk(32'(rresp), 32'(r));
            end
        end
        if (!got) hang();
    endtask : rd

    task wdrdy(input int ch);
        t = 0;
        while (drdy[ch] !== 1'b1) begin
            @(posedge clk);
            t++;
            if (t > 1000) hang();
        end
        @(posedge clk);
    endtask : wdrdy

    // ch1 follows ch0 by the phase setting of 4 ticks
    task gap;
        wdrdy(0);
        wdrdy(1);
        chk(32'(t >= 35 && t <= 42), 32'h1);
    endtask : gap

    task bits(input int ch);
        logic [7:0] s;
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            s = {s[6:0], mout[ch]};
        end
        chk(32'(s == 8'h33 || s == 8'h66 || s == 8'hcc || s == 8'h99), 32'h1);
    endtask : bits

    task snap;
        d0 = c0;
        d1 = c1;
    endtask : snap

    initial begin
        failures = 0;
        n_tests = 0;
        c0 = 0;
        c1 = 0;
        cyc = 0;
        sys_rst = 1'b1;
        rst_n = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CFG, 32'h0, OK);
        rd(PHS, 32'h0, OK);
        rd(8'h14, 32'h0, ERR);
        wr(DT0, 32'h1, ERR);
        wr(PHS, 32'h4, OK);
        wdrdy(0);
        rd(DT0, 32'h005a5a5a, OK);
        wr(CFG, 32'h41, OK);
        wt(10);
        rd(DT0, 32'h0, OK);
        rd(PHS, 32'h4, OK);
        rd(CFG, 32'h41, OK);
        snap();
        wt(3 * P);
        chk(32'(c0 - d0), 32'h0);
        chk(32'(c1 - d1 >= 2), 32'h1);
        chk(32'(core_en), 32'h1);
        bits(0);
        wr(CFG, 32'h0, OK);
        gap();
        wr(CFG, 32'h3, OK);
        wt(10);
        chk(32'(core_en), 32'h0);
        chk(32'(in_en), 32'h1);
        wr(CFG, 32'h0, OK);
        wt(10);
        chk(32'(core_en), 32'h1);
        wr(CFG, 32'h88, OK);
        wt(10);
        rd(DT1, 32'h0, OK);
        rd(CFG, 32'h88, OK);
        snap();
        wt(5 * P);
        chk(32'(c1 - d1), 32'h0);
        chk(32'(c0 - d0 >= 2), 32'h1);
        chk(32'(bias), 32'h1);
        bits(1);
        wr(CFG, 32'h0, OK);
        wt(2);
        chk(32'(bias), 32'h3);
        wdrdy(1);
        chk(32'(t > 2 * P), 32'h1);
        gap();
        wr(CFG, 32'h5, OK);
        wt(10);
        chk(32'(bias), 32'h2);
        wr(CFG, 32'hc, OK);
        wt(10);
        chk(32'(in_en), 32'h0);
        chk(32'(core_en), 32'h0);
        wr(CFG, 32'h3c, OK);
        wt(10);
        chk(32'({ref_en, mon_en, core_en, in_en}), 32'h0);
        rd(CFG, 32'h3c, OK);
        wr(CFG, 32'h1c, OK);
        d0 = cyc;
        wt(30);
        chk(32'(mon_en), 32'h1);
        rd(CFG, 32'h0, OK);
        wdrdy(0);
        chk(32'(cyc - d0 > 2 * P && cyc - d0 < 4 * P + 40), 32'h1);
        wr(CFG, 32'hc0, OK);
        wt(10);
        @(posedge clk);
        rst_n <= 1'b0;
        wt(6);
        snap();
        chk(32'(moe), 32'h0);
        chk(32'(fclr), 32'h1);
        chk(32'(awready), 32'h0);
        wt(2 * P);
        chk(32'(c0 - d0 + c1 - d1), 32'h0);
        rst_n <= 1'b1;
        wt(6);
        rd(CFG, 32'h0, OK);
        rd(DT0, 32'h0, OK);
        test_done();
    end
endmodule : test_adc_reset_shutdown_control

`default_nettype wire
